// file: reset_sequencer.sv
// reset sequencer, cause register, prescale counter, watchdog, irq latch
// assumes: apb master on pclk, pins are asynchronous to pclk
`timescale 1ns/1ns
module reset_sequencer
    import rst_seq_pkg::*;
#(
    parameter int stab_cycles = STAB_CYC
) (
    // apb
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    // reset sources and pin
    input  wire logic                 por_pulse,
    input  wire logic                 lvi_req,
    input  wire logic                 rst_pin_in,
    output logic                      rst_pin_out,
    output logic                      rst_pin_oe,
    // cpu side
    input  wire rst_seq_pkg::cpu_probe_s cpu_probe,
    input  wire logic                 monitor_mode,
    input  wire logic                 break_state,
    input  wire logic                 hv_rst_pin,
    input  wire logic                 hv_irq_pin,
    input  wire logic [NUM_IRQ-1:0]   irq_req,
    input  wire logic                 irq_mask,
    input  wire logic                 irq_start,
    input  wire logic                 irq_serviced,
    output rst_seq_pkg::irq_vec_s     irq_vec,
    output logic                      internal_reset_signal,
    output logic      [15:0]          reset_vector,
    output logic                      clock_gen_output,
    output logic                      module_clk_en,
    output logic                      wdog_tick
);
    import rst_seq_pkg::*;

    if (stab_cycles < 1 || stab_cycles > 65535) begin : g_bad_stab
        $error("stab_cycles out of range");
    end

    typedef enum {S_IDLE, S_STAB, S_DRIVE, S_HOLD} seq_e;
    seq_e seq;
    logic [15:0]      seq_cnt;
    logic [15:0]      low_cnt;
    logic [CNT_W-1:0] presc;
    logic [WDOG_W-1:0] wdog;
    logic [7:0]       cause;
    logic [1:0]       ctrl;
    logic             pin_s1, pin_s2;
    logic             pin_flag_done;
    logic             long_pin;
    logic             wdog_ovf;
    logic             wdog_hit;
    logic             irq_held;
    logic             short_hold;

    wire apb_acc = psel && penable;
    wire apb_wr  = apb_acc && pwrite;
    wire apb_rd  = apb_acc && !pwrite;
    wire svc_wr  = apb_wr && (paddr == SVC_OFS);
    wire wdog_off = (monitor_mode && (hv_rst_pin || hv_irq_pin))
                 || (break_state && hv_rst_pin);
    wire illegal_opcode_flag_ev = cpu_probe.illegal_opcode
                || (cpu_probe.stop_exec && !ctrl[0]);
    wire illegal_address_flag_ev = cpu_probe.opcode_fetch && cpu_probe.unmapped;
    wire soft_ev = (wdog_hit || illegal_opcode_flag_ev || illegal_address_flag_ev) && seq == S_IDLE;
    wire pwr_ev  = por_pulse || lvi_req;

    // watchdog overflow caught asynchronously to the bus clock
    always_ff @(posedge pclk or posedge wdog_ovf or negedge presetn) begin
        if (!presetn)
            wdog_hit <= 1'b0;
        else if (wdog_ovf)
            wdog_hit <= 1'b1;
        else if (seq == S_DRIVE)
            wdog_hit <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= rst_pin_in;
            pin_s2 <= pin_s1;
        end
    end

    // reset sequence state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq        <= S_STAB;
            seq_cnt    <= 16'h0000;
            short_hold <= 1'b0;
        end else if (pwr_ev) begin
            seq        <= S_STAB;
            seq_cnt    <= 16'h0000;
            short_hold <= 1'b0;
        end else begin
            case (seq)
            S_IDLE: begin
                seq_cnt <= 16'h0000;
                if (soft_ev) begin
                    seq        <= S_DRIVE;
                    short_hold <= 1'b1;
                end else if (!pin_s2) begin
                    seq        <= S_HOLD;
                    short_hold <= 1'b0;
                end
            end
            S_STAB: begin
                seq_cnt <= seq_cnt + 16'h0001;
                if (seq_cnt == 16'(stab_cycles - 1)) begin
                    seq     <= S_HOLD;
                    seq_cnt <= 16'h0000;
                end
            end
            S_DRIVE: begin
                seq_cnt <= seq_cnt + 16'h0001;
                if (seq_cnt == 16'(DRIVE_CYC - 1)) begin
                    seq     <= S_HOLD;
                    seq_cnt <= 16'h0000;
                end
            end
            S_HOLD: begin
                if (!pin_s2)
                    seq_cnt <= 16'h0000;
                else
                    seq_cnt <= seq_cnt + 16'h0001;
                if (pin_s2 && seq_cnt == (short_hold ? 16'(HOLD_CYC - 1)
                    : 16'(RELEASE_CYC - 1)))
                    seq <= S_IDLE;
            end
            default: seq <= S_IDLE;
            endcase
        end
    end

    // outputs from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            internal_reset_signal <= 1'b1;
            rst_pin_out           <= 1'b0;
            rst_pin_oe            <= 1'b1;
            clock_gen_output      <= 1'b1;
            module_clk_en         <= 1'b0;
            reset_vector          <= VEC_USER;
        end else begin
            internal_reset_signal <= (seq != S_IDLE) || soft_ev;
            rst_pin_out           <= 1'b0;
            rst_pin_oe            <= seq == S_STAB || seq == S_DRIVE;
            clock_gen_output      <= 1'b1;
            module_clk_en         <= seq != S_STAB;
            reset_vector          <= monitor_mode ? VEC_MON : VEC_USER;
        end
    end

    // pin low counter for the pin flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt       <= 16'h0000;
            long_pin      <= 1'b1;
            pin_flag_done <= 1'b0;
        end else if (pin_s2) begin
            low_cnt       <= 16'h0000;
            long_pin      <= 1'b0;
            pin_flag_done <= 1'b0;
        end else begin
            if (low_cnt != 16'hFFFF)
                low_cnt <= low_cnt + 16'h0001;
            if (pwr_ev)
                long_pin <= 1'b1;
            pin_flag_done <= long_pin ? (low_cnt >= 16'(PIN_MIN_LONG - 1))
                                      : (low_cnt >= 16'(PIN_MIN - 1));
        end
    end

    // cause register: read clears, events win over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause <= CAUSE_RST;
        end else if (por_pulse) begin
            cause <= CAUSE_RST;
        end else begin
            if (apb_rd && paddr == CAUSE_OFS)
                cause <= 8'h00;
            if (pin_flag_done)
                cause[PIN_BIT] <= 1'b1;
            if (wdog_hit && seq == S_IDLE)
                cause[WDOG_BIT] <= 1'b1;
            if (illegal_opcode_flag_ev && seq == S_IDLE)
                cause[ILLEGAL_OPCODE_FLAG_BIT] <= 1'b1;
            if (illegal_address_flag_ev && seq == S_IDLE)
                cause[ILLEGAL_ADDRESS_FLAG_BIT] <= 1'b1;
            if (lvi_req)
                cause[LVI_BIT] <= 1'b1;
        end
    end

    // prescale counter, stepped on pclk standing in for the falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc     <= '0;
            wdog_tick <= 1'b0;
        end else begin
            wdog_tick <= &presc;
            if (soft_ev || pwr_ev)
                presc <= '0;
            else if (svc_wr)
                presc <= presc & CNT_W'(2**WDOG_SVC_LSB - 1);
            else
                presc <= presc + 1'b1;
        end
    end

    // watchdog counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog     <= '0;
            wdog_ovf <= 1'b0;
        end else if (internal_reset_signal || svc_wr || wdog_off) begin
            wdog     <= '0;
            wdog_ovf <= 1'b0;
        end else if (&presc) begin
            wdog     <= wdog + 1'b1;
            wdog_ovf <= &wdog;
        end
    end

    // interrupt latch and arbitration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_vec  <= '0;
            irq_held <= 1'b0;
        end else if (internal_reset_signal || irq_serviced || irq_mask) begin
            irq_vec  <= '0;
            irq_held <= 1'b0;
        end else if (irq_start && !irq_held && |irq_req) begin
            irq_held      <= 1'b1;
            irq_vec.valid <= 1'b1;
            for (int i = NUM_IRQ - 1; i >= 0; i--) begin
                if (irq_req[i])
                    irq_vec.index <= 3'(i);
            end
        end
    end

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl <= CTRL_RST;
        else if (internal_reset_signal)
            ctrl <= CTRL_RST;
        else if (apb_wr && paddr == CTRL_OFS)
            ctrl <= pwdata[1:0];
    end

    // apb answer, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == CAUSE_OFS
                || paddr == CTRL_OFS || paddr == STAT_OFS
                || paddr == SVC_OFS);
            case (paddr)
            CAUSE_OFS: prdata <= {24'h00_0000, cause};
            CTRL_OFS:  prdata <= {30'h0000_0000, ctrl};
            STAT_OFS:  prdata <= {16'h0000, 3'h0, presc};
            default:   prdata <= 32'h0000_0000;
            endcase
        end
    end

    a_drive_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(seq == S_DRIVE) |-> (seq == S_DRIVE) [*8])
        else $error("pin drive too short");
    a_svc_clear: assert property (@(posedge pclk) disable iff (!presetn)
        svc_wr && !soft_ev && !pwr_ev |=> presc[12:4] == 9'h000)
        else $error("service write did not clear prescaler");
    a_por_cause: assert property (@(posedge pclk) disable iff (!presetn)
        por_pulse |=> cause == CAUSE_RST)
        else $error("power-on cause wrong");
    a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rd && paddr == CAUSE_OFS && !por_pulse && !lvi_req
        && !pin_flag_done && !soft_ev |=> cause == 8'h00)
        else $error("cause not cleared on read");
    a_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
        irq_held && !irq_serviced && !irq_mask && !internal_reset_signal
        |=> $stable(irq_vec))
        else $error("latched irq changed");
    a_illegal_opcode_flag_rst: assert property (@(posedge pclk) disable iff (!presetn)
        illegal_opcode_flag_ev && seq == S_IDLE && !pwr_ev |=> seq == S_DRIVE
        ##1 internal_reset_signal)
        else $error("illegal opcode did not reset");
    a_wdog_off: assert property (@(posedge pclk) disable iff (!presetn)
        wdog_off |=> wdog == '0)
        else $error("watchdog not held off");
    a_clk_hold: assert property (@(posedge pclk) disable iff (!presetn)
        seq == S_STAB ##1 seq == S_STAB |-> !module_clk_en)
        else $error("module clocks ran during stabilisation");
endmodule

// file: rst_seq_pkg.sv
// package: constants and carriers for the reset sequencer
// assumes: one 25 MHz clock domain, apb register access
package rst_seq_pkg;
    localparam int    CNT_W          = 13;
    localparam int    PIN_MIN        = 67;
    localparam int    PIN_MIN_LONG   = 4163;
    localparam int    DRIVE_CYC      = 32;
    localparam int    HOLD_CYC       = 32;
    localparam int    STAB_CYC       = 4096;
    localparam int    RELEASE_CYC    = 64;
    localparam int    WDOG_SVC_LSB   = 4;
    localparam int    WDOG_W         = 8;
    localparam int    NUM_IRQ        = 8;
    localparam logic [15:0] VEC_USER = 16'hFFFE;
    localparam logic [15:0] VEC_MON  = 16'hFEFE;
    localparam logic [15:0] WDOG_SVC_ADDR = 16'hFFFF;
    // register byte addresses
    localparam logic [11:0] CAUSE_OFS = 12'h000;
    localparam logic [11:0] CTRL_OFS  = 12'h004;
    localparam logic [11:0] STAT_OFS  = 12'h008;
    localparam logic [11:0] SVC_OFS   = 12'h00C;
    // cause register bits
    localparam int    POR_BIT   = 7;
    localparam int    PIN_BIT   = 6;
    localparam int    WDOG_BIT  = 5;
    localparam int    ILLEGAL_OPCODE_FLAG_BIT  = 4;
    localparam int    ILLEGAL_ADDRESS_FLAG_BIT  = 3;
    localparam int    LVI_BIT   = 1;
    localparam logic [7:0] CAUSE_RST = 8'h80;
    localparam logic [1:0] CTRL_RST  = 2'h0;

    typedef struct packed {
        logic opcode_fetch;
        logic illegal_opcode;
        logic stop_exec;
        logic unmapped;
    } cpu_probe_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] index;
    } irq_vec_s;
endpackage

// file: pin_partner.sv
// partner: board side of the reset pin, a pull-up and a push button
// assumes: device pulls low through rst_pin_out while rst_pin_oe is high
`timescale 1ns/1ns
module pin_partner (
    // device side
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe,
    // board side
    input  wire logic ext_low,
    output logic      rst_pin_in
);
    // wired level: pull-up unless someone pulls low
    assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) & !ext_low;
endmodule

// file: reset_sequencer_bench.sv
// bench: reset sequencer against a small behavioural model
// assumes: pclk at 25 MHz, stabilise count shortened to 16
`timescale 1ns/1ns
module reset_sequencer_bench;
    import rst_seq_pkg::*;
    localparam int STAB = 16;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, s1, seed;
    logic        por_pulse, lvi_req, rst_pin_in, rst_pin_out, rst_pin_oe;
    logic        ext_low, monitor_mode, internal_reset_signal, err;
    logic        clock_gen_output, module_clk_en, wdog_tick;
    logic        irq_start, irq_serviced;
    logic        break_state, hv_rst_pin, hv_irq_pin, irq_mask;
    logic [7:0]  irq_req;
    logic [15:0] reset_vector;
    cpu_probe_s  cpu_probe;
    irq_vec_s    irq_vec;
    int          n_fail = 0, n_tests = 0, cyc = 0, n, m, c1;
    int          exp_q[$];
    int          src_t[5] = '{0, 1, 2, 3, 0};
    int          bit_t[5] = '{ILLEGAL_OPCODE_FLAG_BIT, ILLEGAL_OPCODE_FLAG_BIT, ILLEGAL_ADDRESS_FLAG_BIT, LVI_BIT, ILLEGAL_OPCODE_FLAG_BIT};

    reset_sequencer #(.stab_cycles(STAB)) u_reset_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .por_pulse(por_pulse),
        .lvi_req(lvi_req), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .cpu_probe(cpu_probe), .monitor_mode(monitor_mode),
        .break_state(break_state), .hv_rst_pin(hv_rst_pin),
        .hv_irq_pin(hv_irq_pin),
        .irq_req(irq_req), .irq_mask(irq_mask), .irq_start(irq_start),
        .irq_serviced(irq_serviced), .irq_vec(irq_vec),
        .internal_reset_signal(internal_reset_signal),
        .reset_vector(reset_vector), .clock_gen_output(clock_gen_output),
        .module_clk_en(module_clk_en), .wdog_tick(wdog_tick));

    pin_partner u_pin_partner (
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .ext_low(ext_low), .rst_pin_in(rst_pin_in));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            results();
        end
    end

    task automatic results;
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
            n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // n: cycles the pin stays driven, m: internal reset beyond that
    task automatic seq_watch;
        for (n = 0; rst_pin_oe !== 1'b1 && n < 50; n++)
            @(posedge pclk);
        for (n = 0; rst_pin_oe === 1'b1 && n < 5000; n++)
            @(posedge pclk);
        for (m = 0; internal_reset_signal === 1'b1 && m < 500; m++)
            @(posedge pclk);
    endtask

    // model: read returns the queued cause, a second read returns zero
    task automatic cause_chk;
        apb(1'b0, CAUSE_OFS, 32'h0);
        chk(rd, exp_q.pop_front());
        apb(1'b0, CAUSE_OFS, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic fire(input int src);
        case (src)
            0: cpu_probe.illegal_opcode <= 1'b1;
            1: cpu_probe.stop_exec <= 1'b1;
            2: cpu_probe <= 4'b1001;
            default: lvi_req <= 1'b1;
        endcase
        @(posedge pclk);
        cpu_probe <= '0;
        lvi_req <= 1'b0;
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {presetn, lvi_req, ext_low, monitor_mode} = '0;
        {irq_start, irq_serviced, irq_req, cpu_probe} = '0;
        {break_state, hv_rst_pin, hv_irq_pin, irq_mask} = '0;
        por_pulse = 1'b1;
        seed = 32'h0001_41C8;
        repeat (4) @(posedge pclk);
        chk({internal_reset_signal, rst_pin_oe, module_clk_en, rst_pin_out},
            4'b1100);
        presetn <= 1'b1;
        por_pulse <= 1'b0;
        seq_watch();
        chk(n >= STAB - 1 && n <= STAB + 2, 1'b1);
        chk(m >= RELEASE_CYC, 1'b1);
        chk({clock_gen_output, module_clk_en, reset_vector},
            {2'b11, VEC_USER});
        exp_q.push_back(1 << POR_BIT);
        cause_chk();
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 5; i++) begin
            monitor_mode <= (i == 4);
            c1 = cyc;
            fire(src_t[i]);
            exp_q.push_back(1 << bit_t[i]);
            seq_watch();
            chk(n >= ((i == 3) ? STAB : DRIVE_CYC) - 1, 1'b1);
            chk(n <= ((i == 3) ? STAB : DRIVE_CYC) + 2, 1'b1);
            chk(m >= HOLD_CYC, 1'b1);
            chk(m <= ((i == 3) ? RELEASE_CYC : HOLD_CYC) + 4, 1'b1);
            chk(reset_vector, (i == 4) ? VEC_MON : VEC_USER);
            apb(1'b0, STAT_OFS, 32'h0);
            chk(rd < cyc - c1, 1'b1);
            cause_chk();
        end
        monitor_mode <= 1'b0;
        cpu_probe <= 4'b0001;
        tick(10);
        chk(internal_reset_signal, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h1);
        fire(1);
        tick(10);
        chk(internal_reset_signal, 1'b0);
        for (int w = 100; w > 0; w -= 80) begin
            apb(1'b0, STAT_OFS, 32'h0);
            s1 = rd;
            c1 = cyc;
            ext_low <= 1'b1;
            tick(w);
            ext_low <= 1'b0;
            seq_watch();
            apb(1'b0, STAT_OFS, 32'h0);
            chk(13'(rd - s1 - (cyc - c1)), 13'h0);
            exp_q.push_back((w > PIN_MIN) ? (1 << PIN_BIT) : 0);
            cause_chk();
        end
        for (n = 0; wdog_tick !== 1'b1 && n < 9000; n++)
            @(posedge pclk);
        @(posedge pclk);
        for (n = 1; wdog_tick !== 1'b1 && n < 9000; n++)
            @(posedge pclk);
        chk(n, 1 << CNT_W);
        apb(1'b1, SVC_OFS, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd < 32, 1'b1);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            irq_req <= (seed[7:0] & 8'hFE) | 8'h80;
            tick(1);
            irq_start <= 1'b1;
            tick(1);
            irq_start <= 1'b0;
            tick(2);
            for (m = 0; !irq_req[m]; m++)
                ;
            chk(irq_vec, {1'b1, 3'(m)});
            irq_req <= 8'hFF;
            tick(3);
            chk(irq_vec, {1'b1, 3'(m)});
            irq_serviced <= 1'b1;
            tick(1);
            irq_serviced <= 1'b0;
            tick(2);
            chk(irq_vec.valid, 1'b0);
        end
        irq_req <= 8'h10;
        irq_start <= 1'b1;
        tick(1);
        irq_start <= 1'b0;
        tick(2);
        chk(irq_vec, {1'b1, 3'h4});
        irq_mask <= 1'b1;
        tick(2);
        chk(irq_vec.valid, 1'b0);
        irq_mask <= 1'b0;
        {monitor_mode, hv_irq_pin} <= 2'b11;
        tick(4);
        chk(internal_reset_signal, 1'b0);
        {monitor_mode, hv_irq_pin} <= 2'b00;
        {break_state, hv_rst_pin} <= 2'b11;
        tick(2);
        {break_state, hv_rst_pin} <= 2'b00;
        tick(2);
        chk(internal_reset_signal, 1'b0);
        results();
    end
endmodule
